/* File: verilog/tcmp_pkg.sv */
package tcmp_pkg;

    // ------------------------------------------------------------
    // Register map (word index on the plain register port)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL      = 4'h0;
    localparam logic [3:0] ADDR_COUNT     = 4'h1;
    localparam logic [3:0] ADDR_CMP_A     = 4'h2;
    localparam logic [3:0] ADDR_CMP_B     = 4'h3;
    localparam logic [3:0] ADDR_CAPTURE   = 4'h4;
    localparam logic [3:0] ADDR_FLAGS     = 4'h5;
    localparam logic [3:0] ADDR_FORCE     = 4'h6;
    localparam logic [3:0] ADDR_PORT_OUT  = 4'h7;
    localparam logic [3:0] ADDR_PORT_DIR  = 4'h8;
    localparam logic [3:0] ADDR_STATE     = 4'h9;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_ACT_A_LSB = 4;
    localparam int CTRL_ACT_B_LSB = 6;
    localparam int CTRL_CLK_LSB   = 8;

    // ------------------------------------------------------------
    // Flag register bits
    // ------------------------------------------------------------
    localparam int FLAG_OVF   = 0;
    localparam int FLAG_CMP_A = 1;
    localparam int FLAG_CMP_B = 2;
    localparam int FLAG_CAP   = 3;

    // ------------------------------------------------------------
    // Waveform modes and output actions
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_NORMAL   = 4'h0;
    localparam logic [3:0] MODE_CTC_CMPA = 4'h4;
    localparam logic [3:0] MODE_CTC_CAP  = 4'hc;

    typedef enum logic [1:0] {
        ACT_NONE   = 2'h0,
        ACT_TOGGLE = 2'h1,
        ACT_CLEAR  = 2'h2,
        ACT_SET    = 2'h3
    } tcmp_act_t;

    // ------------------------------------------------------------
    // Count values and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] COUNT_MAX    = 16'hffff;
    localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
    localparam logic [15:0] RST_WORD     = 16'h0000;

    // ------------------------------------------------------------
    // Timer clock source select (divisors of the I/O clock)
    // ------------------------------------------------------------
    localparam logic [2:0] CLK_STOP   = 3'h0;
    localparam logic [2:0] CLK_DIV1   = 3'h1;
    localparam logic [2:0] CLK_DIV8   = 3'h2;
    localparam logic [2:0] CLK_DIV64  = 3'h3;
    localparam logic [2:0] CLK_DIV256 = 3'h4;
    localparam logic [2:0] CLK_DIV1K  = 3'h5;
    localparam logic [9:0] DIV8_LAST   = 10'd7;
    localparam logic [9:0] DIV64_LAST  = 10'd63;
    localparam logic [9:0] DIV256_LAST = 10'd255;
    localparam logic [9:0] DIV1K_LAST  = 10'd1023;

endpackage

/* File: verilog/tcmp_timer.sv */
`timescale 1ns/1ps
// How it works
// - Each channel's action select decides its output state change on the next match.
// - Reset clears every channel's compare output state to low.
// - Nonzero action select makes the pin show compare output state, not port value.
// - Pin direction stays with the port direction bit, even when overridden.
// - Action select bits never affect the capture unit.
// - Action select zero leaves compare output state untouched on a match.
// - A new action select value acts from the first match after the write.
// - In non-PWM modes a force strobe applies the selected action at once.
// - Counting depends on waveform mode and clock select, never on action select.
// - In PWM modes action select picks inverted or non-inverted polarity.
// - In non-PWM modes action select picks set, clear or toggle on match.
// - Mode zero always counts up, never clears, wraps from maximum to zero.
// - Mode zero sets the overflow flag in the cycle the count becomes zero.
// - Overflow interrupt execution clears the overflow flag.
// - In mode zero software may write the counter at any time.
// - Clear-on-match resets count on compare A (mode 4) or capture (mode 12).
// - Reaching top in clear-on-match raises compare A or capture flag accordingly.
// - Top writes act at once; a top below count means running through wrap.
// - In clear-on-match, action one on channel A toggles its output each match.
// - Prescaler divides by 1, 8, 64, 256 or 1024.
// - Clear-on-match also sets overflow when count passes maximum to zero.
// - A compare match sets that channel's compare flag on the next timer cycle.
// - Force changes output state only: no flag, no counter clear or reload.
// - A counter write blocks every compare match in the next timer cycle.
module tcmp_timer #(
    parameter int DATA_W = 16
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Register port
    input  wire logic [3:0]        reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // Interrupt execution acknowledges
    input  wire logic              overflow_ack,
    input  wire logic              compare_a_ack,
    input  wire logic              compare_b_ack,
    input  wire logic              capture_ack,
    // Capture event strobe
    input  wire logic              capture_event,
    // Flag outputs
    output logic                   overflow_flag,
    output logic                   compare_a_flag,
    output logic                   compare_b_flag,
    output logic                   capture_flag,
    // Compare pins, channel A in bit 0
    output logic      [1:0]        compare_pin_out,
    output logic      [1:0]        compare_pin_oe
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic apply_act(input logic cur, input logic [1:0] act);
        logic nxt;
        nxt = cur;
        unique case (tcmp_pkg::tcmp_act_t'(act))
            tcmp_pkg::ACT_NONE:   nxt = cur;
            tcmp_pkg::ACT_TOGGLE: nxt = ~cur;
            tcmp_pkg::ACT_CLEAR:  nxt = 1'b0;
            tcmp_pkg::ACT_SET:    nxt = 1'b1;
        endcase
        return nxt;
    endfunction

    function automatic logic is_wr(input logic wr, input logic [3:0] a, input logic [3:0] r);
        return wr && (a == r);
    endfunction

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    logic [3:0]        waveform_mode_select_q;
    logic [1:0]        output_action_select_q [2];
    logic [2:0]        clk_sel_q;
    logic [15:0]       compare_value_q [2];
    logic [15:0]       capture_value_q;
    logic [1:0]        port_out_q;
    logic [1:0]        compare_pin_direction_q;
    logic [15:0]       count_value_q;
    logic [1:0]        compare_output_state_q;
    logic              block_q;
    logic [9:0]        presc_q;
    logic              tick;
    logic              non_pwm;
    logic              ctc_mode;
    logic [15:0]       top_value;
    logic              top_match;
    logic [1:0]        match;
    logic              wrap;
    logic              count_wr;
    logic              force_wr;
    logic              flags_wr;

    assign count_wr = is_wr(reg_wr, reg_addr, tcmp_pkg::ADDR_COUNT);
    assign force_wr = is_wr(reg_wr, reg_addr, tcmp_pkg::ADDR_FORCE);
    assign flags_wr = is_wr(reg_wr, reg_addr, tcmp_pkg::ADDR_FLAGS);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waveform_mode_select_q    <= 4'h0;
            output_action_select_q[0] <= 2'h0;
            output_action_select_q[1] <= 2'h0;
            clk_sel_q                 <= tcmp_pkg::CLK_STOP;
        end
        else if (is_wr(reg_wr, reg_addr, tcmp_pkg::ADDR_CTRL))
        begin
            waveform_mode_select_q    <= reg_wdata[tcmp_pkg::CTRL_MODE_LSB +: 4];
            output_action_select_q[0] <= reg_wdata[tcmp_pkg::CTRL_ACT_A_LSB +: 2];
            output_action_select_q[1] <= reg_wdata[tcmp_pkg::CTRL_ACT_B_LSB +: 2];
            clk_sel_q                 <= reg_wdata[tcmp_pkg::CTRL_CLK_LSB +: 3];
        end
    end

    // Compare values are written straight through, no double buffer
    generate
        for (genvar ch = 0; ch < 2; ch++)
        begin : g_cmp
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    compare_value_q[ch] <= tcmp_pkg::RST_WORD;
                else if (is_wr(reg_wr, reg_addr, tcmp_pkg::ADDR_CMP_A + 4'(ch)))
                    compare_value_q[ch] <= reg_wdata[15:0];
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_out_q              <= 2'h0;
            compare_pin_direction_q <= 2'h0;
        end
        else
        begin
            if (is_wr(reg_wr, reg_addr, tcmp_pkg::ADDR_PORT_OUT))
                port_out_q <= reg_wdata[1:0];
            if (is_wr(reg_wr, reg_addr, tcmp_pkg::ADDR_PORT_DIR))
                compare_pin_direction_q <= reg_wdata[1:0];
        end
    end

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    always_comb
    begin
        tick = 1'b0;
        unique case (clk_sel_q)
            tcmp_pkg::CLK_DIV1:   tick = 1'b1;
            tcmp_pkg::CLK_DIV8:   tick = (presc_q[2:0] == tcmp_pkg::DIV8_LAST[2:0]);
            tcmp_pkg::CLK_DIV64:  tick = (presc_q[5:0] == tcmp_pkg::DIV64_LAST[5:0]);
            tcmp_pkg::CLK_DIV256: tick = (presc_q[7:0] == tcmp_pkg::DIV256_LAST[7:0]);
            tcmp_pkg::CLK_DIV1K:  tick = (presc_q == tcmp_pkg::DIV1K_LAST);
            default:              tick = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            presc_q <= 10'h000;
        else if (clk_sel_q == tcmp_pkg::CLK_STOP)
            presc_q <= 10'h000;
        else
            presc_q <= presc_q + 10'h001;
    end

    // ------------------------------------------------------------
    // Mode decode and match detection
    // ------------------------------------------------------------
    assign ctc_mode = (waveform_mode_select_q == tcmp_pkg::MODE_CTC_CMPA) ||
                      (waveform_mode_select_q == tcmp_pkg::MODE_CTC_CAP);
    assign non_pwm  = ctc_mode || (waveform_mode_select_q == tcmp_pkg::MODE_NORMAL);
    assign top_value = (waveform_mode_select_q == tcmp_pkg::MODE_CTC_CAP) ?
                       capture_value_q : compare_value_q[0];
    assign wrap      = tick && (count_value_q == tcmp_pkg::COUNT_MAX);

    generate
        for (genvar ch = 0; ch < 2; ch++)
        begin : g_match
            assign match[ch] = tick && !block_q &&
                               (count_value_q == compare_value_q[ch]);
        end
    endgenerate

    assign top_match = ctc_mode && tick && !block_q && (count_value_q == top_value);

    // Match blocking armed by any counter write, held until a timer tick
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            block_q <= 1'b0;
        else if (count_wr)
            block_q <= 1'b1;
        else if (tick)
            block_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            count_value_q <= tcmp_pkg::COUNT_BOTTOM;
        else if (count_wr)
            count_value_q <= reg_wdata[15:0];
        else if (tick)
            count_value_q <= top_match ? tcmp_pkg::COUNT_BOTTOM
                                       : count_value_q + 16'h0001;
    end

    // ------------------------------------------------------------
    // Capture unit, blind to the output action bits
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            capture_value_q <= tcmp_pkg::RST_WORD;
        else if (is_wr(reg_wr, reg_addr, tcmp_pkg::ADDR_CAPTURE))
            capture_value_q <= reg_wdata[15:0];
        else if (capture_event && (waveform_mode_select_q != tcmp_pkg::MODE_CTC_CAP))
            capture_value_q <= count_value_q;
    end

    // ------------------------------------------------------------
    // Flags: hardware set wins over clear
    // ------------------------------------------------------------
    logic ovf_set;
    logic cap_set;

    assign ovf_set = wrap;
    assign cap_set = (waveform_mode_select_q == tcmp_pkg::MODE_CTC_CAP) ?
                     top_match : capture_event;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            overflow_flag <= 1'b0;
        else if (ovf_set)
            overflow_flag <= 1'b1;
        else if (overflow_ack || (flags_wr && reg_wdata[tcmp_pkg::FLAG_OVF]))
            overflow_flag <= 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            compare_a_flag <= 1'b0;
        else if (match[0])
            compare_a_flag <= 1'b1;
        else if (compare_a_ack || (flags_wr && reg_wdata[tcmp_pkg::FLAG_CMP_A]))
            compare_a_flag <= 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            compare_b_flag <= 1'b0;
        else if (match[1])
            compare_b_flag <= 1'b1;
        else if (compare_b_ack || (flags_wr && reg_wdata[tcmp_pkg::FLAG_CMP_B]))
            compare_b_flag <= 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            capture_flag <= 1'b0;
        else if (cap_set)
            capture_flag <= 1'b1;
        else if (capture_ack || (flags_wr && reg_wdata[tcmp_pkg::FLAG_CAP]))
            capture_flag <= 1'b0;
    end

    // ------------------------------------------------------------
    // Compare output state per channel
    // ------------------------------------------------------------
    generate
        for (genvar ch = 0; ch < 2; ch++)
        begin : g_out
            logic       frc;
            logic [1:0] act;
            logic       pwm_inv;

            assign act     = output_action_select_q[ch];
            assign frc     = force_wr && reg_wdata[ch] && non_pwm;
            assign pwm_inv = (act == tcmp_pkg::ACT_SET);

            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    compare_output_state_q[ch] <= 1'b0;
                else if (non_pwm)
                begin
                    if (frc || match[ch])
                        compare_output_state_q[ch] <=
                            apply_act(compare_output_state_q[ch], act);
                end
                else if (act[1])
                begin
                    // Single-slope PWM: match ends the pulse, wrap starts it
                    if (match[ch])
                        compare_output_state_q[ch] <= pwm_inv;
                    else if (wrap)
                        compare_output_state_q[ch] <= ~pwm_inv;
                end
            end

            // Pin override and direction
            assign compare_pin_out[ch] = (act != tcmp_pkg::ACT_NONE) ?
                                         compare_output_state_q[ch] : port_out_q[ch];
            assign compare_pin_oe[ch]  = compare_pin_direction_q[ch];
        end
    endgenerate

    // ------------------------------------------------------------
    // Read port, data one cycle after the strobe
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rd_d;

    always_comb
    begin
        rd_d = '0;
        unique case (reg_addr)
            tcmp_pkg::ADDR_CTRL:
            begin
                rd_d[tcmp_pkg::CTRL_MODE_LSB +: 4]  = waveform_mode_select_q;
                rd_d[tcmp_pkg::CTRL_ACT_A_LSB +: 2] = output_action_select_q[0];
                rd_d[tcmp_pkg::CTRL_ACT_B_LSB +: 2] = output_action_select_q[1];
                rd_d[tcmp_pkg::CTRL_CLK_LSB +: 3]   = clk_sel_q;
            end
            tcmp_pkg::ADDR_COUNT:    rd_d[15:0] = count_value_q;
            tcmp_pkg::ADDR_CMP_A:    rd_d[15:0] = compare_value_q[0];
            tcmp_pkg::ADDR_CMP_B:    rd_d[15:0] = compare_value_q[1];
            tcmp_pkg::ADDR_CAPTURE:  rd_d[15:0] = capture_value_q;
            tcmp_pkg::ADDR_FLAGS:
            begin
                rd_d[tcmp_pkg::FLAG_OVF]   = overflow_flag;
                rd_d[tcmp_pkg::FLAG_CMP_A] = compare_a_flag;
                rd_d[tcmp_pkg::FLAG_CMP_B] = compare_b_flag;
                rd_d[tcmp_pkg::FLAG_CAP]   = capture_flag;
            end
            tcmp_pkg::ADDR_PORT_OUT: rd_d[1:0] = port_out_q;
            tcmp_pkg::ADDR_PORT_DIR: rd_d[1:0] = compare_pin_direction_q;
            tcmp_pkg::ADDR_STATE:    rd_d[1:0] = compare_output_state_q;
            default:                 rd_d = '0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= '0;
        else
            reg_rdata <= reg_rd ? rd_d : '0;
    end

endmodule

/* File: verification/tcmp_timer_monitor.sv */
`timescale 1ns/1ps
module tcmp_monitor #(
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst_n,
    // Register port
    input wire logic [3:0]        reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Acknowledges and events
    input wire logic              overflow_ack,
    input wire logic              compare_a_ack,
    input wire logic              compare_b_ack,
    input wire logic              capture_ack,
    input wire logic              capture_event,
    // Flags and pins
    input wire logic              overflow_flag,
    input wire logic              compare_a_flag,
    input wire logic              compare_b_flag,
    input wire logic              capture_flag,
    input wire logic [1:0]        compare_pin_out,
    input wire logic [1:0]        compare_pin_oe
);
    logic [3:0] mode_q;
    logic [1:0] act_a_q;
    logic [2:0] csel_q;
    logic       port_a_q;
    logic       wr_force;
    logic       wr_flags;

    assign wr_force = reg_wr && reg_addr == tcmp_pkg::ADDR_FORCE && reg_wdata[0];
    assign wr_flags = reg_wr && reg_addr == tcmp_pkg::ADDR_FLAGS;

    // ------------------------------------------------------------
    // Shadow of control and port writes
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q  <= 4'h0;
            act_a_q <= 2'h0;
            csel_q  <= 3'h0;
        end
        else if (reg_wr && reg_addr == tcmp_pkg::ADDR_CTRL)
        begin
            mode_q  <= reg_wdata[3:0];
            act_a_q <= reg_wdata[5:4];
            csel_q  <= reg_wdata[10:8];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            port_a_q <= 1'b0;
        else if (reg_wr && reg_addr == tcmp_pkg::ADDR_PORT_OUT)
            port_a_q <= reg_wdata[0];
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_reset_state_low: assert property ($rose(rst_n) |-> compare_pin_out == 2'h0 && compare_pin_oe == 2'h0)
        else $error("pins not low after reset");
    a_port_value_pass: assert property (act_a_q == 2'h0 |-> compare_pin_out[0] == port_a_q)
        else $error("pin A not showing port value");
    a_dir_follow: assert property (reg_wr && reg_addr == tcmp_pkg::ADDR_PORT_DIR |=> compare_pin_oe == $past(reg_wdata[1:0]))
        else $error("pin enable not following direction");
    a_ovf_on_wrap: assert property (reg_wr && reg_addr == tcmp_pkg::ADDR_COUNT && reg_wdata == 16'hffff && mode_q == 4'h0 && csel_q == 3'h1 |=> ##1 overflow_flag)
        else $error("overflow not set on wrap");
    a_ovf_clear_cause: assert property ($fell(overflow_flag) |-> $past(overflow_ack) || $past(wr_flags && reg_wdata[0]))
        else $error("overflow flag cleared without cause");
    a_cap_evt_flag: assert property (capture_event && mode_q != tcmp_pkg::MODE_CTC_CAP |=> capture_flag)
        else $error("capture event did not set flag");
    a_flag_sticky: assert property (compare_a_flag && !compare_a_ack && !(wr_flags && reg_wdata[1]) |=> compare_a_flag)
        else $error("compare A flag dropped");
    a_force_toggle: assert property (wr_force && act_a_q == 2'h1 && mode_q == 4'h0 && csel_q == 3'h0 |=> compare_pin_out[0] != $past(compare_pin_out[0]))
        else $error("force did not toggle A");
    a_force_no_flag: assert property (wr_force && !compare_a_flag && csel_q == 3'h0 |=> !compare_a_flag)
        else $error("force set compare A flag");
endmodule

bind tcmp_timer tcmp_monitor #(.DATA_W(DATA_W)) u_mon (.*);

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic        overflow_ack = 1'b0, compare_a_ack = 1'b0, compare_b_ack = 1'b0;
    logic        capture_ack = 1'b0, capture_event = 1'b0;
    logic        overflow_flag, compare_a_flag, compare_b_flag, capture_flag;
    logic [1:0]  compare_pin_out, compare_pin_oe;
    logic [31:0] seed = 32'd89;
    int          bad_count = 0, check_count = 0;
    int          divs [3] = '{1, 8, 64};
    logic [2:0]  sels [3] = '{tcmp_pkg::CLK_DIV1, tcmp_pkg::CLK_DIV8, tcmp_pkg::CLK_DIV64};

    tcmp_timer dut (.*);

    always #12.5 clk = ~clk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction

    function automatic logic [1:0] nxt(input logic [1:0] s, input logic [1:0] a);
        case (a)
            2'h1: return ~s;
            2'h2: return 2'h0;
            2'h3: return 2'h3;
            default: return s;
        endcase
    endfunction

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic ctrl(input logic [3:0] m, input logic [1:0] a, input logic [2:0] s);
        wr(tcmp_pkg::ADDR_CTRL, {5'h00, s, a, a, m});
    endtask

    // Edges until pin A changes
    task automatic period(output int n);
        logic p;
        n = 0;
        p = compare_pin_out[0];
        while (compare_pin_out[0] === p && n < 5000)
        begin
            tick(1);
            n++;
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (100000) @(posedge clk);
        bad_count++;
        summarize();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        logic [15:0] v, c0;
        logic [1:0]  st, port, a;
        int          n, c;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("pin_out", 16'(compare_pin_out), 16'h0000);
        chk("pin_oe", 16'(compare_pin_oe), 16'h0000);
        rd(tcmp_pkg::ADDR_STATE, v);
        chk("state", v, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 6; i++)
        begin
            v = xs();
            wr(tcmp_pkg::ADDR_PORT_OUT, {14'h0, v[1:0]});
            wr(tcmp_pkg::ADDR_PORT_DIR, {14'h0, v[3:2]});
            #1;
            chk("pin_out", 16'(compare_pin_out), {14'h0, v[1:0]});
            chk("pin_oe", 16'(compare_pin_oe), {14'h0, v[3:2]});
        end
        port = v[1:0];
        $display("test port done");
        ctrl(tcmp_pkg::MODE_NORMAL, 2'h0, tcmp_pkg::CLK_STOP);
        wr(tcmp_pkg::ADDR_FLAGS, 16'h000f);
        rd(tcmp_pkg::ADDR_COUNT, c0);
        st = 2'h0;
        for (int i = 0; i < 12; i++)
        begin
            v = xs();
            a = (i < 4) ? 2'(i) : v[1:0];
            ctrl(tcmp_pkg::MODE_NORMAL, a, tcmp_pkg::CLK_STOP);
            wr(tcmp_pkg::ADDR_FORCE, 16'h0003);
            st = nxt(st, a);
            rd(tcmp_pkg::ADDR_STATE, v);
            chk("state", v, {14'h0, st});
            chk("pin_out", 16'(compare_pin_out), {14'h0, (a == 2'h0) ? port : st});
        end
        rd(tcmp_pkg::ADDR_FLAGS, v);
        chk("flags", v, 16'h0000);
        rd(tcmp_pkg::ADDR_COUNT, v);
        chk("count", v, c0);
        $display("test force done");
        ctrl(tcmp_pkg::MODE_NORMAL, 2'h0, tcmp_pkg::CLK_DIV1);
        wr(tcmp_pkg::ADDR_FLAGS, 16'h000f);
        wr(tcmp_pkg::ADDR_COUNT, 16'hffff);
        #1;
        chk("ovf", 16'(overflow_flag), 16'h0000);
        tick(1);
        chk("ovf", 16'(overflow_flag), 16'h0001);
        @(posedge clk);
        overflow_ack <= 1'b1;
        capture_event <= 1'b1;
        @(posedge clk);
        overflow_ack <= 1'b0;
        capture_event <= 1'b0;
        #1;
        chk("ovf", 16'(overflow_flag), 16'h0000);
        chk("cap_flag", 16'(capture_flag), 16'h0001);
        wr(tcmp_pkg::ADDR_CMP_A, 16'h0400);
        wr(tcmp_pkg::ADDR_FLAGS, 16'h000f);
        wr(tcmp_pkg::ADDR_COUNT, 16'h03ff);
        tick(1);
        chk("cmp_a_flag", 16'(compare_a_flag), 16'h0000);
        tick(1);
        chk("cmp_a_flag", 16'(compare_a_flag), 16'h0001);
        wr(tcmp_pkg::ADDR_FLAGS, 16'h000f);
        wr(tcmp_pkg::ADDR_COUNT, 16'h0400);
        tick(3);
        chk("cmp_a_flag", 16'(compare_a_flag), 16'h0000);
        $display("test normal done");
        for (int m = 0; m < 2; m++)
            for (int k = 0; k < 3; k++)
            begin
                v = xs();
                c = 2 + int'(v[2:0]);
                wr(tcmp_pkg::ADDR_CAPTURE, 16'(c));
                wr(tcmp_pkg::ADDR_CMP_A, (m == 0) ? 16'(c) : 16'h0000);
                ctrl((m == 0) ? tcmp_pkg::MODE_CTC_CMPA : tcmp_pkg::MODE_CTC_CAP,
                     tcmp_pkg::ACT_TOGGLE, sels[k]);
                wr(tcmp_pkg::ADDR_COUNT, 16'h0000);
                wr(tcmp_pkg::ADDR_FLAGS, 16'h000f);
                period(n);
                period(n);
                chk("period", 16'(n), 16'((c + 1) * divs[k]));
                chk("top_flag", 16'((m == 0) ? compare_a_flag : capture_flag), 16'h0001);
            end
        $display("test clear on match done");
        ctrl(tcmp_pkg::MODE_CTC_CMPA, 2'h0, tcmp_pkg::CLK_DIV1);
        wr(tcmp_pkg::ADDR_CMP_A, 16'h0005);
        wr(tcmp_pkg::ADDR_COUNT, 16'hfff0);
        wr(tcmp_pkg::ADDR_FLAGS, 16'h000f);
        tick(14);
        chk("ovf", 16'(overflow_flag), 16'h0001);
        chk("cmp_a_flag", 16'(compare_a_flag), 16'h0000);
        tick(8);
        chk("cmp_a_flag", 16'(compare_a_flag), 16'h0001);
        chk("cmp_b_flag", 16'(compare_b_flag), 16'h0001);
        $display("test top below count done");
        summarize();
    end
endmodule
